// ### square_wave_out_aging_supply_switch.sv
// square-wave output, crystal aging trim and supply switch-over policy
`timescale 1ns/1ps
module square_wave_out_aging_supply_switch #(
  parameter int adj_w = 8 // width of the compensation adjustment
) (
  input wire logic clk_sys, // system clock, 20 mhz
  input wire logic reset_n, // asynchronous reset, active low
  input wire logic osc_pin, // raw oscillator
  input wire logic main_below_backup, // comparator result
  input wire logic main_below_threshold, // comparator result
  input wire logic battery_low, // comparator result
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  input wire logic [7:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // register write data
  output logic [7:0] reg_rdata, // register read data
  output logic reg_rdata_oe, // read data driven
  input wire logic signed [adj_w-1:0] temp_comp_adj, // temperature adjust in
  output logic signed [adj_w-1:0] total_comp_adj, // adjust with aging term
  output logic square_wave_out, // programmable square wave
  output logic square_wave_oe, // square wave driven
  output logic backed_supply_out, // running from backup
  output logic backup_irq, // backup switch interrupt
  output logic battery_irq, // battery weak interrupt
  output logic stamp_capture // pulse: capture time into stamp set four
);
  rtc_link_if link ();

  osc_prescaler u_pre (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .osc_pin(osc_pin),
    .link(link)
  );

  supply_monitor u_sup (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .main_below_backup(main_below_backup),
    .main_below_threshold(main_below_threshold),
    .battery_low(battery_low),
    .link(link)
  );

  logic [2:0] freq_select;
  logic [2:0] next_freq_select;
  logic [3:0] aging_trim_code;
  logic [3:0] next_aging_trim_code;
  logic [2:0] policy;
  logic [2:0] next_policy;
  logic stamp_en;
  logic next_stamp_en;
  logic backup_flag;
  logic next_backup_flag;
  logic backup_irq_en;
  logic next_backup_irq_en;
  logic weak_irq_en;
  logic next_weak_irq_en;
  logic host_wr;
  logic host_rd;
  logic [7:0] read_word;
  logic [7:0] next_rdata;
  logic next_rdata_oe;
  rtc_power_pkg::switch_mode_e mode;
  logic lowdet_en;
  logic signed [5:0] aging_corr;
  logic signed [adj_w-1:0] next_total;
  logic next_square;
  logic next_square_oe;
  logic next_stamp;

  // host access is cut off while on backup
  assign host_wr = reg_wr && !link.on_backup;
  assign host_rd = reg_rd && !link.on_backup;

  // policy decode
  always_comb
  begin
    mode = rtc_power_pkg::mode_off;
    lowdet_en = 1'b0;
    case (policy)
      3'h0:
      begin
        mode = rtc_power_pkg::mode_standard;
        lowdet_en = 1'b1;
      end
      3'h1, 3'h2: mode = rtc_power_pkg::mode_standard;
      3'h3:
      begin
        mode = rtc_power_pkg::mode_direct;
        lowdet_en = 1'b1;
      end
      3'h4, 3'h5: mode = rtc_power_pkg::mode_direct;
      default: mode = rtc_power_pkg::mode_off;
    endcase
  end

  assign link.switch_mode = mode;
  assign link.lowdet_en = lowdet_en;

  // register file next values
  always_comb
  begin
    next_freq_select = freq_select;
    next_aging_trim_code = aging_trim_code;
    next_policy = policy;
    next_stamp_en = stamp_en;
    next_backup_irq_en = backup_irq_en;
    next_weak_irq_en = weak_irq_en;
    next_backup_flag = backup_flag;
    if (host_wr)
    begin
      case (reg_addr)
        rtc_power_pkg::addr_output_freq_control: next_freq_select = reg_wdata[2:0];
        rtc_power_pkg::addr_crystal_aging_trim: next_aging_trim_code = reg_wdata[3:0];
        rtc_power_pkg::addr_supply_ctl:
        begin
          next_policy = reg_wdata[rtc_power_pkg::pos_policy_lsb +: 3];
          next_stamp_en = reg_wdata[rtc_power_pkg::pos_stamp_en];
          next_backup_irq_en = reg_wdata[rtc_power_pkg::pos_backup_irq_en];
          next_weak_irq_en = reg_wdata[rtc_power_pkg::pos_weak_irq_en];
          if (!reg_wdata[rtc_power_pkg::pos_backup_flag])
          begin
            next_backup_flag = 1'b0;
          end
        end
        default: next_policy = policy;
      endcase
    end
    // a new switch event wins over a simultaneous clear
    if (link.fail_event)
    begin
      next_backup_flag = 1'b1;
    end
    if (mode == rtc_power_pkg::mode_off)
    begin
      next_backup_flag = 1'b0;
    end
  end

  // read mux; unused bits and unmapped addresses read zero
  always_comb
  begin
    read_word = 8'h00;
    case (reg_addr)
      rtc_power_pkg::addr_output_freq_control: read_word = {5'h00, freq_select};
      rtc_power_pkg::addr_crystal_aging_trim: read_word = {4'h0, aging_trim_code};
      rtc_power_pkg::addr_supply_ctl:
      begin
        read_word[rtc_power_pkg::pos_policy_lsb +: 3] = policy;
        read_word[rtc_power_pkg::pos_stamp_en] = stamp_en;
        read_word[rtc_power_pkg::pos_backup_flag] = backup_flag;
        read_word[rtc_power_pkg::pos_weak_flag] = link.batt_weak;
        read_word[rtc_power_pkg::pos_backup_irq_en] = backup_irq_en;
        read_word[rtc_power_pkg::pos_weak_irq_en] = weak_irq_en;
      end
      default: read_word = 8'h00;
    endcase
    next_rdata = host_rd ? read_word : reg_rdata;
    next_rdata_oe = !link.on_backup;
  end

  // aging correction: +16 ppm at code 0, falling 2 ppm per code
  always_comb
  begin
    aging_corr = $signed(rtc_power_pkg::aging_zero_offset - {1'b0, aging_trim_code, 1'b0});
    next_total = adj_w'(temp_comp_adj + {{(adj_w-6){aging_corr[5]}}, aging_corr});
  end

  // square wave selection from raw oscillator or prescaler taps
  always_comb
  begin
    case (freq_select)
      rtc_power_pkg::sel_raw: next_square = link.osc_level;
      3'h1: next_square = link.div_count[0];
      3'h2: next_square = link.div_count[1];
      3'h3: next_square = link.div_count[2];
      3'h4: next_square = link.div_count[3];
      3'h5: next_square = link.div_count[4];
      rtc_power_pkg::sel_1hz: next_square = link.div_count[rtc_power_pkg::prescale_bits-1];
      default: next_square = 1'b0;
    endcase
    next_square_oe = (freq_select != rtc_power_pkg::sel_off) && !link.on_backup;
    next_stamp = link.fail_event && stamp_en;
  end

  // state and output registers
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      freq_select <= rtc_power_pkg::reset_freq_select;
      aging_trim_code <= rtc_power_pkg::reset_aging_trim;
      policy <= rtc_power_pkg::reset_policy;
      stamp_en <= 1'b0;
      backup_flag <= 1'b0;
      backup_irq_en <= 1'b0;
      weak_irq_en <= 1'b0;
      reg_rdata <= 8'h00;
      reg_rdata_oe <= 1'b1;
      total_comp_adj <= '0;
      square_wave_out <= 1'b0;
      square_wave_oe <= 1'b1;
      backed_supply_out <= 1'b0;
      backup_irq <= 1'b0;
      battery_irq <= 1'b0;
      stamp_capture <= 1'b0;
    end
    else
    begin
      freq_select <= next_freq_select;
      aging_trim_code <= next_aging_trim_code;
      policy <= next_policy;
      stamp_en <= next_stamp_en;
      backup_flag <= next_backup_flag;
      backup_irq_en <= next_backup_irq_en;
      weak_irq_en <= next_weak_irq_en;
      reg_rdata <= next_rdata;
      reg_rdata_oe <= next_rdata_oe;
      total_comp_adj <= next_total;
      square_wave_out <= next_square;
      square_wave_oe <= next_square_oe;
      backed_supply_out <= link.on_backup;
      backup_irq <= backup_flag && backup_irq_en;
      battery_irq <= link.batt_weak && weak_irq_en;
      stamp_capture <= next_stamp;
    end
  end

  // switch event followed by the flag standing
  sequence switch_seq;
    link.fail_event ##1 backup_flag;
  endsequence

  flag_on_switch_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (link.fail_event && mode != rtc_power_pkg::mode_off) |-> switch_seq)
    else $error("backup flag not set by switch event");
  irq_gating_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ##1 (backup_irq == ($past(backup_flag) && $past(backup_irq_en))))
    else $error("backup interrupt not gated by its enable");
  stamp_pulse_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (link.fail_event && stamp_en) |=> stamp_capture ##1 !stamp_capture)
    else $error("stamp capture pulse wrong");
  flag_holds_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (backup_flag && !host_wr && mode != rtc_power_pkg::mode_off) |=> backup_flag)
    else $error("backup flag dropped without host clear");
  backup_float_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    link.on_backup |=> (!square_wave_oe && !reg_rdata_oe))
    else $error("outputs driven while on backup");
  flag_off_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (mode == rtc_power_pkg::mode_off) |=> !backup_flag)
    else $error("backup flag set while switch-over off");
  high_z_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (freq_select == rtc_power_pkg::sel_off) |=> !square_wave_oe)
    else $error("square wave driven at select 111");
  aging_map_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (aging_trim_code == 4'h8) |=> (total_comp_adj == $past(temp_comp_adj)))
    else $error("aging code 1000 not zero correction");
  trim_read_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (host_rd && reg_addr == rtc_power_pkg::addr_crystal_aging_trim) |=>
    (reg_rdata[7:4] == 4'h0))
    else $error("aging trim upper bits not zero");
  weak_irq_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (link.batt_weak && weak_irq_en) |=> battery_irq)
    else $error("battery weak interrupt missing");
  one_hz_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (freq_select == rtc_power_pkg::sel_1hz) |=>
    (square_wave_out == $past(link.div_count[rtc_power_pkg::prescale_bits-1])))
    else $error("1 hz tap not selected");

  // host cut-off on backup, detection enable, raw and first taps
  refused_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (link.on_backup && reg_wr) |=>
    ($stable(aging_trim_code) && $stable(freq_select)))
    else $error("register written while on backup");
  weak_off_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !lowdet_en |=> !link.batt_weak)
    else $error("battery weak flag set with detection off");
  div_tap_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (freq_select == 3'h1) |=> (square_wave_out == $past(link.div_count[0])))
    else $error("16384 hz tap not selected");
  raw_tap_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (freq_select == rtc_power_pkg::sel_raw) |=> (square_wave_out == $past(link.osc_level)))
    else $error("raw oscillator not selected");
endmodule

// ### rtc_power_pkg.sv
// constants shared by the clock-output, aging-trim and supply-policy logic
package rtc_power_pkg;
  // register addresses
  localparam logic [7:0] addr_supply_ctl = 8'h02;
  localparam logic [7:0] addr_output_freq_control = 8'h13;
  localparam logic [7:0] addr_crystal_aging_trim = 8'h30;
  // field positions in the supply control register
  localparam int pos_policy_lsb = 5;
  localparam int pos_stamp_en = 4;
  localparam int pos_backup_flag = 3;
  localparam int pos_weak_flag = 2;
  localparam int pos_backup_irq_en = 1;
  localparam int pos_weak_irq_en = 0;
  // values after reset
  localparam logic [2:0] reset_freq_select = 3'h0;
  localparam logic [3:0] reset_aging_trim = 4'h8;
  localparam logic [2:0] reset_policy = 3'h7;
  // frequency select codes
  localparam logic [2:0] sel_raw = 3'h0;
  localparam logic [2:0] sel_1hz = 3'h6;
  localparam logic [2:0] sel_off = 3'h7;
  // prescaler length: divide by 32768 for the 1 hz tap
  localparam int prescale_bits = 15;
  // aging correction: code 0 gives +16 ppm in 2 ppm steps
  localparam logic [5:0] aging_zero_offset = 6'h10;
  // supply policies
  typedef enum logic [1:0] {
    mode_off = 2'b00,
    mode_standard = 2'b01,
    mode_direct = 2'b10
  } switch_mode_e;
endpackage

// ### rtc_link_if.sv
// signals between the control core, the prescaler and the supply monitor
`timescale 1ns/1ps
interface rtc_link_if;
  logic osc_level;
  logic [rtc_power_pkg::prescale_bits-1:0] div_count;
  rtc_power_pkg::switch_mode_e switch_mode;
  logic lowdet_en;
  logic on_backup;
  logic fail_event;
  logic batt_weak;
  modport pre (output osc_level, output div_count);
  modport sup (input switch_mode, input lowdet_en, output on_backup, output fail_event,
    output batt_weak);
  modport core (input osc_level, input div_count, output switch_mode, output lowdet_en,
    input on_backup, input fail_event, input batt_weak);
endinterface

// ### osc_prescaler.sv
// oscillator synchroniser and binary prescaler counting raw oscillator cycles
`timescale 1ns/1ps
module osc_prescaler (
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // asynchronous reset, active low
  input wire logic osc_pin, // raw 32.768 khz oscillator
  rtc_link_if.pre link // clean level and counter out
);
  logic [2:0] sync;
  logic clean;
  logic next_clean;
  logic [rtc_power_pkg::prescale_bits-1:0] count;
  logic [rtc_power_pkg::prescale_bits-1:0] next_count;

  // a change counts once the second and third stages agree
  always_comb
  begin
    next_clean = (sync[1] == sync[2]) ? sync[2] : clean;
    next_count = count;
    if (next_clean && !clean)
    begin
      next_count = count + 1'b1;
    end
  end

  // register stages; counter runs from the uncompensated oscillator
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync <= 3'h0;
      clean <= 1'b0;
      count <= '0;
    end
    else
    begin
      sync <= {sync[1:0], osc_pin};
      clean <= next_clean;
      count <= next_count;
    end
  end

  assign link.osc_level = clean;
  assign link.div_count = count;
endmodule

// ### supply_monitor.sv
// comparator synchronisers and switch-over decision
`timescale 1ns/1ps
module supply_monitor (
  input wire logic clk_sys, // system clock
  input wire logic reset_n, // asynchronous reset, active low
  input wire logic main_below_backup, // comparator: main supply under backup
  input wire logic main_below_threshold, // comparator: main supply under threshold
  input wire logic battery_low, // comparator: battery under low level
  rtc_link_if.sup link // policy in, supply state out
);
  logic [2:0] raw;
  logic [2:0] stage1;
  logic [2:0] stage2;
  logic [2:0] stage3;
  logic [2:0] clean;
  logic [2:0] next_clean;
  logic on_backup;
  logic next_on_backup;
  logic fail_event;
  logic next_fail_event;
  logic batt_weak;
  logic next_batt_weak;

  assign raw = {battery_low, main_below_threshold, main_below_backup};

  // per comparator: accept a change once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < 3; i++)
    begin : g_sync
      assign next_clean[i] = (stage2[i] == stage3[i]) ? stage3[i] : clean[i];
    end
  endgenerate

  // power failure decision per policy
  always_comb
  begin
    case (link.switch_mode)
      rtc_power_pkg::mode_standard: next_on_backup = clean[0] && clean[1];
      rtc_power_pkg::mode_direct: next_on_backup = clean[0];
      default: next_on_backup = 1'b0;
    endcase
    next_fail_event = next_on_backup && !on_backup;
    next_batt_weak = link.lowdet_en && clean[2];
  end

  // register stages and decision
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1 <= 3'h0;
      stage2 <= 3'h0;
      stage3 <= 3'h0;
      clean <= 3'h0;
      on_backup <= 1'b0;
      fail_event <= 1'b0;
      batt_weak <= 1'b0;
    end
    else
    begin
      stage1 <= raw;
      stage2 <= stage1;
      stage3 <= stage2;
      clean <= next_clean;
      on_backup <= next_on_backup;
      fail_event <= next_fail_event;
      batt_weak <= next_batt_weak;
    end
  end

  assign link.on_backup = on_backup;
  assign link.fail_event = fail_event;
  assign link.batt_weak = batt_weak;

  standard_mode_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (link.switch_mode == rtc_power_pkg::mode_standard && !clean[1]) |=> !on_backup)
    else $error("backup taken while main above threshold");
  direct_mode_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (link.switch_mode == rtc_power_pkg::mode_direct) |=> (on_backup == $past(clean[0])))
    else $error("direct mode did not follow backup comparison");
endmodule

// ### host_model.sv
// host processor model driving the register strobe port
`timescale 1ns/1ps
module host_model (
  input wire logic clk_sys, // system clock
  output logic reg_wr, // write strobe
  output logic reg_rd, // read strobe
  output logic [7:0] reg_addr, // address
  output logic [7:0] reg_wdata, // write data
  input wire logic [7:0] reg_rdata // read data
);
  // quiet bus at time zero
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // let the taking edge pass, then drop strobes; idle lines show inverted stale values
  task automatic idle_bus();
    @(posedge clk_sys);
    #2;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask
  // one write, entered just after a clock edge; an idle edge follows so the next
  // request never reassigns a line in the time step in which this one dropped it
  task automatic write(input logic [7:0] addr, input logic [7:0] data);
    reg_addr = addr;
    reg_wdata = data;
    reg_wr = 1'b1;
    idle_bus();
    @(posedge clk_sys);
    #2;
  endtask
  // one read, data taken once the registered answer has landed
  task automatic read(input logic [7:0] addr, output logic [7:0] data);
    reg_addr = addr;
    reg_rd = 1'b1;
    idle_bus();
    @(posedge clk_sys);
    #2;
    data = reg_rdata;
  endtask
endmodule

// ### tb.sv
// self-checking bench for clock output, aging trim and supply policy
`timescale 1ns/1ps
`define chk(what, exp, got) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("FAIL %s expected %h seen %h", what, exp, got); \
    end \
  end
module tb;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic osc_pin = 1'b0;
  logic main_below_backup = 1'b0;
  logic main_below_threshold = 1'b0;
  logic battery_low = 1'b0;
  logic signed [7:0] temp_comp_adj = 8'sh05;
  logic reg_wr, reg_rd, reg_rdata_oe, square_wave_out, square_wave_oe;
  logic backed_supply_out, backup_irq, battery_irq, stamp_capture;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
  logic signed [7:0] total_comp_adj;
  int mismatches = 0;
  int cmp_count = 0;
  int stamps = 0;
  // system clock and an oscillator stand-in of 16 clock cycles
  always #25 clk_sys = ~clk_sys;
  always
  begin
    repeat (8) @(posedge clk_sys);
    #2 osc_pin = ~osc_pin;
  end
  // count capture pulses away from the launching edge
  always @(negedge clk_sys) stamps += int'(stamp_capture === 1'b1);
  host_model host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  square_wave_out_aging_supply_switch #(.adj_w(8)) uut (.clk_sys(clk_sys), .reset_n(reset_n),
    .osc_pin(osc_pin), .main_below_backup(main_below_backup),
    .main_below_threshold(main_below_threshold), .battery_low(battery_low),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rdata_oe(reg_rdata_oe), .temp_comp_adj(temp_comp_adj),
    .total_comp_adj(total_comp_adj), .square_wave_out(square_wave_out),
    .square_wave_oe(square_wave_oe), .backed_supply_out(backed_supply_out),
    .backup_irq(backup_irq), .battery_irq(battery_irq), .stamp_capture(stamp_capture));
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  task automatic chk_reg(input string what, input logic [7:0] addr, input logic [7:0] exp);
    host.read(addr, rd);
    `chk(what, exp, rd)
  endtask
  // high and low times of one full square-wave period, in clock cycles
  task automatic measure(output int hi, output int lo);
    hi = 0;
    lo = 0;
    for (int i = 0; i < 2000 && square_wave_out !== 1'b0; i++) step(1);
    for (int i = 0; i < 2000 && square_wave_out !== 1'b1; i++) step(1);
    while (square_wave_out === 1'b1 && hi < 2000)
    begin
      step(1);
      hi++;
    end
    while (square_wave_out === 1'b0 && lo < 2000)
    begin
      step(1);
      lo++;
    end
  endtask
  // every select code: raw, five divided taps, slow tap, off
  task automatic test_square_wave_out();
    int hi;
    int lo;
    chk_reg("freq reset", rtc_power_pkg::addr_output_freq_control, 8'h00);
    `chk("oe reset", 1'b1, square_wave_oe)
    measure(hi, lo);
    `chk("raw duty", 1'b1, hi >= 6 && hi <= 10)
    for (int c = 1; c <= 5; c++)
    begin
      host.write(rtc_power_pkg::addr_output_freq_control, 8'(c));
      step(8);
      measure(hi, lo);
      `chk("div high", 8 << c, hi)
      `chk("div low", 8 << c, lo)
    end
    host.write(rtc_power_pkg::addr_output_freq_control, 8'h06);
    step(8);
    hi = int'(square_wave_out);
    lo = 0;
    for (int i = 0; i < 1000; i++)
    begin
      step(1);
      lo += int'(square_wave_out !== hi[0]);
    end
    `chk("slow tap still", 0, lo)
    host.write(rtc_power_pkg::addr_output_freq_control, 8'hff);
    chk_reg("freq upper", rtc_power_pkg::addr_output_freq_control, 8'h07);
    `chk("off oe", 1'b0, square_wave_oe)
    host.write(rtc_power_pkg::addr_output_freq_control, 8'h00);
  endtask
  // all sixteen trim codes, with the temperature term moving as well
  task automatic test_aging();
    chk_reg("trim reset", rtc_power_pkg::addr_crystal_aging_trim, 8'h08);
    host.write(rtc_power_pkg::addr_crystal_aging_trim, 8'hff);
    chk_reg("trim upper", rtc_power_pkg::addr_crystal_aging_trim, 8'h0f);
    for (int c = 0; c < 16; c++)
    begin
      temp_comp_adj = 8'(c - 8);
      host.write(rtc_power_pkg::addr_crystal_aging_trim, 8'(c));
      step(2);
      `chk("aging adj", 8'(8 - c), total_comp_adj)
    end
    host.write(rtc_power_pkg::addr_crystal_aging_trim, 8'h08);
  endtask
  // one supply dip under a policy, then recovery and flag clear
  task automatic power_fail(input logic [2:0] pol, input logic st, input logic backup_switch_irq_en,
    input logic bb, input logic bt, input logic sw);
    int s0;
    host.write(rtc_power_pkg::addr_supply_ctl, {pol, st, 2'b10, backup_switch_irq_en, 1'b0});
    s0 = stamps;
    main_below_backup = bb;
    main_below_threshold = bt;
    step(12);
    `chk("on backup", sw, backed_supply_out)
    `chk("square_wave_out off", ~sw, square_wave_oe)
    `chk("rdata off", ~sw, reg_rdata_oe)
    `chk("backup irq", sw & backup_switch_irq_en, backup_irq)
    `chk("stamp", int'(sw & st), stamps - s0)
    host.write(rtc_power_pkg::addr_crystal_aging_trim, 8'h03);
    main_below_backup = 1'b0;
    main_below_threshold = 1'b0;
    step(12);
    `chk("back on main", 1'b0, backed_supply_out)
    `chk("irq held", sw & backup_switch_irq_en, backup_irq)
    chk_reg("flag held", rtc_power_pkg::addr_supply_ctl, {pol, st, sw, 1'b0, backup_switch_irq_en, 1'b0});
    chk_reg("trim refused", rtc_power_pkg::addr_crystal_aging_trim, sw ? 8'h08 : 8'h03);
    host.write(rtc_power_pkg::addr_supply_ctl, {pol, st, 2'b00, backup_switch_irq_en, 1'b0});
    step(1);
    chk_reg("flag cleared", rtc_power_pkg::addr_supply_ctl, {pol, st, 2'b00, backup_switch_irq_en, 1'b0});
    `chk("irq released", 1'b0, backup_irq)
    host.write(rtc_power_pkg::addr_crystal_aging_trim, 8'h08);
  endtask
  // battery weak detection per policy; host write must not clear it
  task automatic test_weak(input logic [2:0] pol, input logic en);
    host.write(rtc_power_pkg::addr_supply_ctl, {pol, 5'b01001});
    battery_low = 1'b1;
    step(8);
    `chk("weak irq", en, battery_irq)
    host.write(rtc_power_pkg::addr_supply_ctl, {pol, 5'b00001});
    chk_reg("weak flag", rtc_power_pkg::addr_supply_ctl, {pol, 2'b00, en, 2'b01});
    battery_low = 1'b0;
    step(8);
    chk_reg("weak recover", rtc_power_pkg::addr_supply_ctl, {pol, 5'b00001});
  endtask
  // a second reset in mid-run brings every register back to its value after reset
  task automatic test_rerun_reset();
    host.write(rtc_power_pkg::addr_output_freq_control, 8'h03);
    host.write(rtc_power_pkg::addr_crystal_aging_trim, 8'h02);
    reset_n = 1'b0;
    step(4);
    reset_n = 1'b1;
    step(1);
    chk_reg("freq rerun", rtc_power_pkg::addr_output_freq_control, 8'h00);
    chk_reg("trim rerun", rtc_power_pkg::addr_crystal_aging_trim, 8'h08);
    chk_reg("ctl rerun", rtc_power_pkg::addr_supply_ctl, 8'he0);
    `chk("oe rerun", 1'b1, square_wave_oe)
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // watchdog well beyond the expected run of under four thousand cycles
  initial
  begin
    #2ms;
    mismatches++;
    close_out();
  end
  // main sequence
  initial
  begin
    step(4);
    reset_n = 1'b1;
    step(1);
    chk_reg("ctl reset", rtc_power_pkg::addr_supply_ctl, 8'he0);
    chk_reg("unmapped", 8'h55, 8'h00);
    test_square_wave_out();
    test_aging();
    power_fail(3'b000, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    power_fail(3'b000, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    power_fail(3'b010, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    power_fail(3'b011, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
    power_fail(3'b100, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
    power_fail(3'b101, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    power_fail(3'b110, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
    power_fail(3'b111, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
    for (int p = 0; p < 8; p++) test_weak(3'(p), p == 0 || p == 3);
    test_rerun_reset();
    close_out();
  end
endmodule
